// ### src/ipm_priority_map.sv
// Interrupt arbiter register map with priority register zero arbitration
// Function
// - Bits 15-14 of priority register zero select clock-lock request level.
// - Code 00 disables, 01/10/11 select levels one to three; reset 00.
// - Bits 13-12 select low-voltage request level, disabled after reset.
// - Bits 9-8 select debug-port receive-full request level, disabled at reset.
// - Present chosen level to core if at or above core mask; highest level wins, lowest source within it.
`timescale 1ns/1ps
module ipm_priority_map
  import ipm_pkg::*;
#(
  parameter int SRC_CLOCK_LOCK = 1,
  parameter int SRC_LOW_VOLTAGE = 2,
  parameter int SRC_DEBUG_RX = 3
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Peripheral bus slave
  input wire logic [4:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [15:0] bus_rdata_out,
  // Interrupt sources
  input wire logic [IPM_NSRC-1:0] irq_in,
  // Core side
  input wire logic [1:0] core_mask_in,
  output logic core_irq_out,
  output logic [1:0] core_level_out,
  output logic [6:0] core_vector_out,
  output logic [20:0] core_addr_out,
  output logic core_fast_out
);

  typedef struct packed {
    logic [6:0][15:0] prio;
    logic [13:0] vbase;
    logic [5:0] fmatch0;
    logic [5:0] fmatch1;
    logic [15:0] fvlow0;
    logic [15:0] fvlow1;
    logic [4:0] fvhigh0;
    logic [4:0] fvhigh1;
    logic int_dis;
    logic [IPM_NSRC-1:0] pend;
    logic [15:0] rdata;
    logic irq;
    logic [1:0] level;
    logic [1:0] pic;
    logic [6:0] vec;
    logic [20:0] addr;
    logic fast;
  } ipm_state_s;

  ipm_state_s s_q;
  ipm_state_s s_d;

  // Field code matches a level; shared by every level lane
  function automatic logic ipm_code_hit(input logic [1:0] code, input int lvl);
    ipm_code_hit = (code != IPM_CODE_OFF) && (code == 2'(lvl));
  endfunction : ipm_code_hit

  // Source codes pulled from priority register zero
  logic [1:0] clock_lock_irq_level;
  logic [1:0] low_voltage_irq_level;
  logic [1:0] debug_rx_full_irq_level;
  assign clock_lock_irq_level = s_q.prio[0][IPM_POS_CLOCK_LOCK +: 2];
  assign low_voltage_irq_level = s_q.prio[0][IPM_POS_LOW_VOLTAGE +: 2];
  assign debug_rx_full_irq_level = s_q.prio[0][IPM_POS_DEBUG_RX +: 2];

  // Per-level request vectors; sources without a decoded field stay out
  logic [3:1][IPM_NSRC-1:0] lvl_req;
  logic [3:1] lvl_hit;
  logic [3:1][IPM_IDXW-1:0] lvl_idx;
  logic [IPM_NSRC-1:0] live;

  always_comb begin
    lvl_req = '0;
    for (int l = 1; l <= 3; l++) begin
      lvl_req[l][SRC_CLOCK_LOCK] = irq_in[SRC_CLOCK_LOCK] &&
        ipm_code_hit(clock_lock_irq_level, l);
      lvl_req[l][SRC_LOW_VOLTAGE] = irq_in[SRC_LOW_VOLTAGE] &&
        ipm_code_hit(low_voltage_irq_level, l);
      lvl_req[l][SRC_DEBUG_RX] = irq_in[SRC_DEBUG_RX] &&
        ipm_code_hit(debug_rx_full_irq_level, l);
    end
    live = lvl_req[1] | lvl_req[2] | lvl_req[3];
  end

  // One lowest-index finder per level
  genvar gl;
  generate
    for (gl = 1; gl <= 3; gl++) begin : g_lvl
      ipm_lowest_enc #(
        .N(IPM_NSRC),
        .W(IPM_IDXW)
      ) u_enc (
        .req_in(lvl_req[gl]),
        .hit_out(lvl_hit[gl]),
        .idx_out(lvl_idx[gl])
      );
    end
  endgenerate

  // Winner: highest level first, lowest source within it
  logic win_hit;
  logic [1:0] win_lvl;
  logic [IPM_IDXW-1:0] win_idx;
  logic permit;
  logic fast0;
  logic fast1;

  always_comb begin
    win_hit = 1'b0;
    win_lvl = 2'h0;
    win_idx = '0;
    for (int l = 1; l <= 3; l++) begin
      if (lvl_hit[l]) begin
        win_hit = 1'b1;
        win_lvl = 2'(l);
        win_idx = lvl_idx[l];
      end
    end
    // Core accepts only levels at or above its mask setting
    permit = win_hit && !s_q.int_dis && (win_lvl >= core_mask_in);
    fast0 = (win_lvl == 2'h2) && (win_idx == s_q.fmatch0);
    fast1 = (win_lvl == 2'h2) && (win_idx == s_q.fmatch1) && !fast0;
  end

  // Next-state: register writes, read mux, core outputs
  always_comb begin
    s_d = s_q;
    // Bus write; reserved bits are dropped so they always read zero
    if (bus_wr_in) begin
      if (bus_addr_in <= IPM_OFS_PRIO6) begin
        s_d.prio[bus_addr_in[2:0]] = bus_wdata_in;
        if (bus_addr_in == IPM_OFS_PRIO0) begin
          s_d.prio[0] = bus_wdata_in & ~IPM_PRIO0_RSVD_MASK;
        end
        if (bus_addr_in == IPM_OFS_PRIO6) begin
          s_d.prio[6] = bus_wdata_in & ~IPM_PRIO6_RSVD_MASK;
        end
      end else begin
        unique case (bus_addr_in)
          IPM_OFS_VBASE: s_d.vbase = bus_wdata_in[13:0];
          IPM_OFS_FMATCH0: s_d.fmatch0 = bus_wdata_in[5:0];
          IPM_OFS_FVLOW0: s_d.fvlow0 = bus_wdata_in;
          IPM_OFS_FVHIGH0: s_d.fvhigh0 = bus_wdata_in[4:0];
          IPM_OFS_FMATCH1: s_d.fmatch1 = bus_wdata_in[5:0];
          IPM_OFS_FVLOW1: s_d.fvlow1 = bus_wdata_in;
          IPM_OFS_FVHIGH1: s_d.fvhigh1 = bus_wdata_in[4:0];
          IPM_OFS_CTRL: s_d.int_dis = bus_wdata_in[IPM_CTRL_DIS_BIT];
          default: s_d.int_dis = s_q.int_dis; // Read-only or unmapped
        endcase
      end
    end

    // Pending view holds only requests that may arbitrate
    s_d.pend = live;

    // Read data registered one cycle after the strobe
    s_d.rdata = 16'h0000;
    if (bus_rd_in) begin
      if (bus_addr_in <= IPM_OFS_PRIO6) begin
        s_d.rdata = s_q.prio[bus_addr_in[2:0]];
      end else if (bus_addr_in >= IPM_OFS_PEND0 && bus_addr_in <= IPM_OFS_PEND3) begin
        s_d.rdata = s_q.pend[16 * 32'(bus_addr_in - IPM_OFS_PEND0) +: 16];
      end else begin
        unique case (bus_addr_in)
          IPM_OFS_VBASE: s_d.rdata = {2'h0, s_q.vbase};
          IPM_OFS_FMATCH0: s_d.rdata = {10'h000, s_q.fmatch0};
          IPM_OFS_FVLOW0: s_d.rdata = s_q.fvlow0;
          IPM_OFS_FVHIGH0: s_d.rdata = {11'h000, s_q.fvhigh0};
          IPM_OFS_FMATCH1: s_d.rdata = {10'h000, s_q.fmatch1};
          IPM_OFS_FVLOW1: s_d.rdata = s_q.fvlow1;
          IPM_OFS_FVHIGH1: s_d.rdata = {11'h000, s_q.fvhigh1};
          IPM_OFS_CTRL: begin
            s_d.rdata = IPM_CTRL_ONES;
            s_d.rdata[IPM_CTRL_INT_BIT] = s_q.irq;
            s_d.rdata[14:13] = s_q.pic;
            s_d.rdata[12:6] = s_q.vec;
            s_d.rdata[IPM_CTRL_DIS_BIT] = s_q.int_dis;
          end
          default: s_d.rdata = 16'h0000; // Unmapped reads zero
        endcase
      end
    end

    // Core presentation; level 1 maps to code 10, levels 2-3 to 11
    s_d.irq = permit;
    s_d.level = permit ? win_lvl : 2'h0;
    s_d.pic = !permit ? IPM_PIC_NONE : (win_lvl == 2'h1) ? IPM_PIC_LVL1 : IPM_PIC_LVL23;
    s_d.vec = permit ? {1'b0, win_idx} : 7'h00;
    s_d.fast = permit && (fast0 || fast1);
    // Fast vectors bypass the base-plus-number address
    if (permit && fast0) begin
      s_d.addr = {s_q.fvhigh0, s_q.fvlow0};
    end else if (permit && fast1) begin
      s_d.addr = {s_q.fvhigh1, s_q.fvlow1};
    end else if (permit) begin
      s_d.addr = {s_q.vbase, 1'b0, win_idx};
    end else begin
      s_d.addr = 21'h000000;
    end
  end

  // State register; all priority fields start disabled
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.prio <= {7{IPM_RST_PRIO}};
      s_q.vbase <= IPM_RST_VBASE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign bus_rdata_out = s_q.rdata;
  assign core_irq_out = s_q.irq;
  assign core_level_out = s_q.level;
  assign core_vector_out = s_q.vec;
  assign core_addr_out = s_q.addr;
  assign core_fast_out = s_q.fast;

endmodule : ipm_priority_map

// ### src/ipm_pkg.sv
// Register map, field layout and reset values of the interrupt priority map
package ipm_pkg;

  // Register offsets (word addresses)
  localparam logic [4:0] IPM_OFS_PRIO0 = 5'h00;
  localparam logic [4:0] IPM_OFS_PRIO6 = 5'h06;
  localparam logic [4:0] IPM_OFS_VBASE = 5'h07;
  localparam logic [4:0] IPM_OFS_FMATCH0 = 5'h08;
  localparam logic [4:0] IPM_OFS_FVLOW0 = 5'h09;
  localparam logic [4:0] IPM_OFS_FVHIGH0 = 5'h0A;
  localparam logic [4:0] IPM_OFS_FMATCH1 = 5'h0B;
  localparam logic [4:0] IPM_OFS_FVLOW1 = 5'h0C;
  localparam logic [4:0] IPM_OFS_FVHIGH1 = 5'h0D;
  localparam logic [4:0] IPM_OFS_PEND0 = 5'h0E;
  localparam logic [4:0] IPM_OFS_PEND3 = 5'h11;
  localparam logic [4:0] IPM_OFS_CTRL = 5'h16;

  // Priority register zero field positions (low bit of each pair)
  localparam int IPM_POS_CLOCK_LOCK = 14;
  localparam int IPM_POS_LOW_VOLTAGE = 12;
  localparam int IPM_POS_DEBUG_RX = 8;
  localparam logic [15:0] IPM_PRIO0_RSVD_MASK = 16'h0C00;
  localparam logic [15:0] IPM_PRIO6_RSVD_MASK = 16'hF000;

  // Levels-one-to-three field codes
  localparam logic [1:0] IPM_CODE_OFF = 2'h0;

  // Core presented level encoding
  localparam logic [1:0] IPM_PIC_NONE = 2'h0;
  localparam logic [1:0] IPM_PIC_LVL0 = 2'h1;
  localparam logic [1:0] IPM_PIC_LVL1 = 2'h2;
  localparam logic [1:0] IPM_PIC_LVL23 = 2'h3;

  // Control register layout
  localparam int IPM_CTRL_INT_BIT = 15;
  localparam int IPM_CTRL_DIS_BIT = 5;
  localparam logic [15:0] IPM_CTRL_ONES = 16'h001C;

  // Reset values
  localparam logic [15:0] IPM_RST_PRIO = 16'h0000;
  localparam logic [13:0] IPM_RST_VBASE = 14'h0000;

  // Widths
  localparam int IPM_NSRC = 64;
  localparam int IPM_IDXW = 6;

endpackage : ipm_pkg

// ### src/ipm_lowest_enc.sv
// Lowest-numbered active request finder
`timescale 1ns/1ps
module ipm_lowest_enc #(
  parameter int N = 64,
  parameter int W = 6
) (
  // Requests
  input wire logic [N-1:0] req_in,
  // Result
  output logic hit_out,
  output logic [W-1:0] idx_out
);

  // Scan downward so the lowest index is left standing
  always_comb begin
    hit_out = 1'b0;
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        hit_out = 1'b1;
        idx_out = W'(i);
      end
    end
  end

endmodule : ipm_lowest_enc

// ### test/ipm_core_model.sv
// Core-side partner that offers the status-register mask
`timescale 1ns/1ps
module ipm_core_model (
  // Clock
  input wire logic clk_sys_in,
  // Mask asked for by the bench
  input wire logic [1:0] mask_sel_in,
  // Towards the arbiter
  output logic [1:0] core_mask_out
);
  // Mask moves only on a core clock edge, as a real core would
  always_ff @(posedge clk_sys_in) begin
    core_mask_out <= mask_sel_in;
  end
endmodule : ipm_core_model

// ### test/ipm_priority_map_chk.sv
// Port checker for the interrupt priority map
`timescale 1ns/1ps
module ipm_priority_map_chk (
  // Watched ports
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [4:0] bus_addr_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [15:0] bus_rdata_out,
  input wire logic [63:0] irq_in,
  input wire logic [1:0] core_mask_in,
  input wire logic core_irq_out,
  input wire logic [1:0] core_level_out,
  input wire logic [6:0] core_vector_out,
  input wire logic [20:0] core_addr_out,
  input wire logic core_fast_out
);
  logic [63:0] irq_q;
  logic [15:0] p0_q;
  logic [15:0] p0_qq;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Shadows lag one edge (irq_q) or two (p0_qq) so they line up with the registered outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_q <= '0;
      p0_q <= '0;
      p0_qq <= '0;
    end else begin
      irq_q <= irq_in;
      p0_qq <= p0_q;
      if (bus_wr_in && bus_addr_in == 5'h00) p0_q <= bus_wdata_in;
    end
  end
  property p_idle; !core_irq_out |-> core_level_out == 2'h0 && core_vector_out == 7'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("level or vector without request");
  property p_lvl_nz; core_irq_out |-> core_level_out != 2'h0; endproperty
  a_lvl_nz: assert property (p_lvl_nz) else $error("request at disabled level");
  property p_mask; core_irq_out |-> core_level_out >= $past(core_mask_in); endproperty
  a_mask: assert property (p_mask) else $error("masked level presented");
  property p_src; core_irq_out |-> irq_q[core_vector_out[5:0]]; endproperty
  a_src: assert property (p_src) else $error("winner not requesting");
  property p_vec; core_irq_out |-> core_vector_out inside {7'h01, 7'h02, 7'h03}; endproperty
  a_vec: assert property (p_vec) else $error("vector outside mapped sources");
  property p_rsvd; bus_rd_in && bus_addr_in == 5'h00 |=> bus_rdata_out[11:10] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_rdback; bus_rd_in && !bus_wr_in && bus_addr_in == 5'h00
    |=> bus_rdata_out == (p0_qq & 16'hF300); endproperty
  a_rdback: assert property (p_rdback) else $error("priority zero readback");
  property p_map; core_irq_out |-> core_level_out == (core_vector_out == 7'h01 ?
    p0_qq[15:14] : core_vector_out == 7'h02 ? p0_qq[13:12] : p0_qq[9:8]); endproperty
  a_map: assert property (p_map) else $error("level differs from field");
  property p_addr_idle; !core_irq_out |-> core_addr_out == 21'h000000 && !core_fast_out;
  endproperty
  a_addr_idle: assert property (p_addr_idle) else $error("address without request");
  property p_fast_lvl; core_fast_out |-> core_irq_out && core_level_out == 2'h2; endproperty
  a_fast_lvl: assert property (p_fast_lvl) else $error("fast vector off level two");
  cover property (core_fast_out);
  cover property (core_irq_out && core_level_out == 2'h3);
  cover property (core_irq_out && core_vector_out == 7'h02);
  cover property (bus_rd_in && bus_addr_in == 5'h00);
endmodule : ipm_priority_map_chk
bind ipm_priority_map ipm_priority_map_chk u_ipm_priority_map_chk (.*);

// ### test/test_ipm_priority_map.sv
// Self-checking bench for the interrupt priority map
`timescale 1ns/1ps
module test_ipm_priority_map;
  import ipm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [63:0] irq = '0;
  logic [1:0] mask_sel = 2'h0;
  logic [1:0] mask;
  logic cirq;
  logic [1:0] lvl;
  logic [6:0] vec;
  logic [20:0] caddr;
  logic cfast;
  int bad_count = 0;
  int compares = 0;
  // Clock
  always #5 clk_sys_in = ~clk_sys_in;
  ipm_priority_map u_ipm_priority_map (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd),
    .bus_rdata_out(rdata), .irq_in(irq), .core_mask_in(mask), .core_irq_out(cirq),
    .core_level_out(lvl), .core_vector_out(vec), .core_addr_out(caddr),
    .core_fast_out(cfast));
  ipm_core_model u_ipm_core_model (.clk_sys_in(clk_sys_in), .mask_sel_in(mask_sel),
    .core_mask_out(mask));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Fast flag above the 21-bit vector address
  task automatic addr_cmp(input string name, input logic [21:0] exp, input logic [21:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : addr_cmp
  // Strobe held over exactly one taken edge
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_in) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_sys_in) #1;
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input string name, input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk_sys_in) #1;
    rd = 1'b0;
    chk(name, exp, rdata);
  endtask : rd_chk
  // Three edges cover mask registering plus output latency
  task automatic core_chk(input logic [15:0] exp);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("core", exp, {6'h00, cirq, lvl, vec});
  endtask : core_chk
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // Watchdog, far beyond the hundred-odd cycles needed
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    #1 rst_in = 1'b0;
    rd_chk("prio0", IPM_OFS_PRIO0, 16'h0000);
    irq[3:1] = 3'h7;
    core_chk(16'h0000);
    rd_chk("pend0", IPM_OFS_PEND0, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr_reg(IPM_OFS_PRIO0, 16'(c) << 14);
      core_chk(c == 0 ? 16'h0000 : {6'h00, 1'b1, 2'(c), 7'h01});
    end
    // Clock-lock held at level one, low-voltage swept
    for (int c = 1; c < 4; c++) begin
      wr_reg(IPM_OFS_PRIO0, 16'h4000 | (16'(c) << 12));
      core_chk({6'h00, 1'b1, 2'(c), c == 1 ? 7'h01 : 7'h02});
    end
    wr_reg(IPM_OFS_PRIO0, 16'h0300);
    core_chk({6'h00, 1'b1, 2'h3, 7'h03});
    wr_reg(IPM_OFS_PRIO0, 16'hF300);
    rd_chk("prio0", IPM_OFS_PRIO0, 16'hF300);
    core_chk({6'h00, 1'b1, 2'h3, 7'h01});
    rd_chk("pend0", IPM_OFS_PEND0, 16'h000E);
    irq[1] = 1'b0;
    core_chk({6'h00, 1'b1, 2'h3, 7'h02});
    irq[1] = 1'b1;
    wr_reg(IPM_OFS_PRIO0, 16'h8000);
    mask_sel = 2'h3;
    core_chk(16'h0000);
    mask_sel = 2'h2;
    core_chk({6'h00, 1'b1, 2'h2, 7'h01});
    wr_reg(IPM_OFS_CTRL, 16'h0020);
    core_chk(16'h0000);
    rd_chk("ctrl", IPM_OFS_CTRL, 16'h003C);
    wr_reg(IPM_OFS_CTRL, 16'h0000);
    core_chk({6'h00, 1'b1, 2'h2, 7'h01});
    rd_chk("ctrl", IPM_OFS_CTRL, 16'hE05C);
    addr_cmp("vaddr", 22'h000001, {cfast, caddr});
    // Base plus source number, then the fast vector at level two
    wr_reg(IPM_OFS_VBASE, 16'h0123);
    rd_chk("vbase", IPM_OFS_VBASE, 16'h0123);
    core_chk({6'h00, 1'b1, 2'h2, 7'h01});
    addr_cmp("vaddr", 22'h009181, {cfast, caddr});
    wr_reg(IPM_OFS_FVLOW0, 16'h5A5A);
    wr_reg(IPM_OFS_FVHIGH0, 16'h0015);
    wr_reg(IPM_OFS_FMATCH0, 16'h0001);
    core_chk({6'h00, 1'b1, 2'h2, 7'h01});
    addr_cmp("faddr", 22'h355A5A, {cfast, caddr});
    // Fast match applies only at level two
    wr_reg(IPM_OFS_PRIO0, 16'hC000);
    core_chk({6'h00, 1'b1, 2'h3, 7'h01});
    addr_cmp("vaddr", 22'h009181, {cfast, caddr});
    // Mid-run reset puts every field back to disabled
    @(posedge clk_sys_in) #1 rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 rst_in = 1'b0;
    rd_chk("prio0", IPM_OFS_PRIO0, 16'h0000);
    core_chk(16'h0000);
    addr_cmp("vaddr", 22'h000000, {cfast, caddr});
    test_done();
  end
endmodule : test_ipm_priority_map
